// file: core/pm_regs.svh
// register offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef PM_REGS_SVH
`define PM_REGS_SVH

// register offsets (8-bit register pointer)
`define REG_CFG            8'h00
`define REG_CURRENT        8'h01
`define REG_BUS            8'h02
`define REG_POWER          8'h03
`define REG_MASK           8'h06

// measurement_configuration fields
`define CFG_MODE_HI        2
`define CFG_MODE_LO        0
`define CFG_ISH_CT_HI      5
`define CFG_ISH_CT_LO      3
`define CFG_BUS_CT_HI      8
`define CFG_BUS_CT_LO      6
`define CFG_AVG_HI         11
`define CFG_AVG_LO         9
`define CFG_RESET          16'h0007

// operating-mode bits: bit 0 converts current, bit 1 converts bus voltage, bit 2 runs continuously
`define MODE_SHUNT_BIT     0
`define MODE_BUS_BIT       1
`define MODE_CONT_BIT      2
`define MODE_CONT_BOTH     3'h7
`define MODE_PD_TRIG       3'h0
`define MODE_PD_CONT       3'h4

// alert_mask_and_flags fields
`define MASK_READY_BIT     3
`define MASK_WR_BITS       16'hfc03
`define MASK_RESET         16'h0000

// power scaling: 1.25 mA x 1.25 mV per code product, 10 mW per power code
`define PWR_DIVISOR        32'd6400
`define PWR_MAX            32'h0000_ffff

// timing
`define CLK_PERIOD_NS      50
`define WAKE_TIME_NS       40000
`define WAKE_CYCLES        ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// accumulator widths: 16-bit samples plus up to 1024 samples
`define ACC_W              26
`define CNT_W              11
`define TMR_W              10

`endif

// file: core/pm_pkg.sv
// types shared by the conversion sequencer and its sample accumulator
`include "pm_regs.svh"

package pm_pkg;

  typedef enum logic [2:0] {
    ST_POWER_DOWN,
    ST_WAKE,
    ST_START,
    ST_SHUNT,
    ST_BUS,
    ST_CALC,
    ST_LOAD,
    ST_IDLE
  } seq_state_t;

  typedef struct packed {
    logic signed [`ACC_W-1:0] cur_sum;
    logic        [`ACC_W-1:0] bus_sum;
    logic        [`ACC_W-1:0] pwr_sum;
  } acc_state_t;

  typedef struct packed {
    seq_state_t        state;
    logic [15:0]       cfg;
    logic [15:0]       mask_bits;
    logic              ready;
    logic [`CNT_W-1:0] count;
    logic [`TMR_W-1:0] timer;
    logic [15:0]       cur_sample;
    logic [15:0]       bus_sample;
    logic [15:0]       pwr_sample;
    logic [15:0]       cur_out;
    logic [15:0]       bus_out;
    logic [15:0]       pwr_out;
    logic [15:0]       rdata;
    logic              adc_start;
    logic              adc_sel_bus;
  } seq_regs_t;

endpackage : pm_pkg

// file: core/sample_accumulator.sv
// running sums of current, bus voltage and power with power-of-two averaging
`timescale 1ns/1ps
`include "pm_regs.svh"

module sample_accumulator
  import pm_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // control
  input  wire logic        clear_i,
  input  wire logic        add_i,
  input  wire logic [3:0]  shift_i,
  // one sample set
  input  wire logic [15:0] cur_i,
  input  wire logic [15:0] bus_i,
  input  wire logic [15:0] pwr_i,
  // averages of the sums
  output logic      [15:0] cur_avg_o,
  output logic      [15:0] bus_avg_o,
  output logic      [15:0] pwr_avg_o
);

  acc_state_t q;
  acc_state_t d;
  logic signed [`ACC_W-1:0] cur_shift;
  logic        [`ACC_W-1:0] bus_shift;
  logic        [`ACC_W-1:0] pwr_shift;

  // clear and add together starts a fresh sum with this sample
  always_comb begin
    d = q;
    if (clear_i) begin
      d.cur_sum = '0;
      d.bus_sum = '0;
      d.pwr_sum = '0;
    end
    if (add_i) begin
      d.cur_sum = (clear_i ? '0 : q.cur_sum) + `ACC_W'(signed'(cur_i));
      d.bus_sum = (clear_i ? '0 : q.bus_sum) + `ACC_W'(bus_i);
      d.pwr_sum = (clear_i ? '0 : q.pwr_sum) + `ACC_W'(pwr_i);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // averaging counts are powers of two, so the mean is a right shift, arithmetic only for the signed current sum
  assign cur_shift = q.cur_sum >>> shift_i;
  assign bus_shift = q.bus_sum >> shift_i;
  assign pwr_shift = q.pwr_sum >> shift_i;
  assign cur_avg_o = cur_shift[15:0];
  assign bus_avg_o = bus_shift[15:0];
  assign pwr_avg_o = pwr_shift[15:0];

endmodule : sample_accumulator

// file: core/conversion_sequencer.sv
// conversion sequencing, averaging and result registers of the current, bus-voltage and power monitor
`timescale 1ns/1ps
`include "pm_regs.svh"

// Function
// [R1] mode 111 converts current then bus voltage continuously, sequence after sequence.
// [R2] each current sample is computed from the shunt code, then power from it.
// [R3] every sequence adds into the accumulator until the programmed averaging count.
// [R4] output registers load only after full averaging and hold until the next result.
// [R5] reading output registers never disturbs the conversion in progress.
// [R6] modes exist converting only current or only bus voltage.
// [R7] writing mode 001, 010 or 011 starts one single-shot measurement set.
// [R8] every configuration write restarts a single shot, even with the same mode.
// [R9] power-down mode exists; leaving it waits 40 us before converting.
// [R10] registers stay readable and writable in power-down.
// [R11] power-down lasts until an active mode is written to configuration.
// [R12] ready flag sets only when conversions, averaging and multiplication are done.
// [R13] configuration writes clear the ready flag, except writes selecting power-down.
// [R14] reading the mask/flags register clears the ready flag.
// [R15] current and power math runs beside conversion, not adding conversion time; the code spends one ST_CALC cycle on it after each sequence.
// [R16] per-sample values go only to the accumulator unless averaging is one.
// [R17] bus voltage code weighs 1.25 mV per bit, full scale 40.96 V.
// [R18] negative current reads as two's complement; power always reads positive.
// [R19] after a single shot the block idles, results held, until a configuration write.
module conversion_sequencer
  import pm_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // converter
  output logic             adc_start_o,
  output logic             adc_sel_bus_o,
  output logic      [2:0]  adc_conv_time_o,
  output logic             analog_pd_o,
  input  wire logic        adc_done_i,
  input  wire logic [15:0] adc_data_i,
  // status
  output logic             conversion_ready_flag_o
);

  seq_regs_t q;
  seq_regs_t d;

  logic        cfg_wr;
  logic        mask_wr;
  logic        mask_rd;
  logic [2:0]  mode;
  logic [2:0]  new_mode;
  logic        new_is_pd;
  logic [3:0]  avg_shift;
  logic        acc_clear;
  logic        acc_add;
  logic        load_evt;
  logic [15:0] cur_avg;
  logic [15:0] bus_avg;
  logic [15:0] pwr_avg;

  // averaging code to log2 of sample count: 1, 4, 16, 64, 128, 256, 512, 1024
  function automatic logic [3:0] avg_log2(input logic [2:0] code);
    case (code)
      3'h0:    avg_log2 = 4'h0;
      3'h1:    avg_log2 = 4'h2;
      3'h2:    avg_log2 = 4'h4;
      3'h3:    avg_log2 = 4'h6;
      3'h4:    avg_log2 = 4'h7;
      3'h5:    avg_log2 = 4'h8;
      3'h6:    avg_log2 = 4'h9;
      default: avg_log2 = 4'ha;
    endcase
  endfunction : avg_log2

  // power code from current and bus codes; the magnitude keeps power positive
  function automatic logic [15:0] calc_power(input logic [15:0] cur, input logic [15:0] bus);
    logic [15:0] mag;
    logic [31:0] prod;
    mag  = cur[15] ? 16'(-cur) : cur;
    prod = (32'(mag) * 32'(bus)) / `PWR_DIVISOR;
    calc_power = (prod > `PWR_MAX) ? 16'hffff : prod[15:0];
  endfunction : calc_power

  function automatic logic is_power_down(input logic [2:0] m);
    is_power_down = (m == `MODE_PD_TRIG) || (m == `MODE_PD_CONT);
  endfunction : is_power_down

  assign mode      = q.cfg[`CFG_MODE_HI:`CFG_MODE_LO];
  assign new_mode  = reg_wdata_i[`CFG_MODE_HI:`CFG_MODE_LO];
  assign new_is_pd = is_power_down(new_mode);
  assign avg_shift = avg_log2(q.cfg[`CFG_AVG_HI:`CFG_AVG_LO]);
  assign cfg_wr    = reg_wr_i && (reg_addr_i == `REG_CFG);
  assign mask_wr   = reg_wr_i && (reg_addr_i == `REG_MASK);
  assign mask_rd   = reg_rd_i && (reg_addr_i == `REG_MASK);

  always_comb begin
    d           = q;
    d.adc_start = 1'b0;
    acc_clear   = 1'b0;
    acc_add     = 1'b0;
    load_evt    = 1'b0;

    // sequencing
    case (q.state)
      ST_POWER_DOWN: begin
        d.state = ST_POWER_DOWN; // see [R11]
      end
      ST_WAKE: begin
        if (q.timer == `TMR_W'(`WAKE_CYCLES - 1)) begin
          d.timer = '0;
          d.state = ST_START; // see [R9]
        end else begin
          d.timer = q.timer + 1'b1;
        end
      end
      ST_START: begin
        d.adc_start = 1'b1;
        if (mode[`MODE_SHUNT_BIT]) begin
          d.adc_sel_bus = 1'b0; // see [R1]
          d.state       = ST_SHUNT;
        end else begin
          d.adc_sel_bus = 1'b1; // see [R6]
          d.state       = ST_BUS;
        end
      end
      ST_SHUNT: begin
        if (adc_done_i) begin
          // integrated shunt makes the shunt code the current code directly
          d.cur_sample = adc_data_i; // see [R2] [R18]
          if (mode[`MODE_BUS_BIT]) begin
            d.adc_start   = 1'b1; // see [R1]
            d.adc_sel_bus = 1'b1;
            d.state       = ST_BUS;
          end else begin
            d.state = ST_CALC; // see [R6]
          end
        end
      end
      ST_BUS: begin
        if (adc_done_i) begin
          d.bus_sample = adc_data_i; // see [R17]
          d.state      = ST_CALC;
        end
      end
      ST_CALC: begin
        // one cycle against conversions of many microseconds
        d.pwr_sample = calc_power(q.cur_sample, q.bus_sample); // see [R2] [R15] [R18]
        acc_add      = 1'b1; // see [R3] [R16]
        if (q.count == `CNT_W'((1 << avg_shift) - 1)) begin
          d.count = '0;
          d.state = ST_LOAD;
        end else begin
          d.count = q.count + 1'b1; // see [R3]
          d.state = ST_START;
        end
      end
      ST_LOAD: begin
        d.cur_out = cur_avg; // see [R4] [R16]
        d.bus_out = bus_avg;
        d.pwr_out = pwr_avg;
        acc_clear = 1'b1;
        load_evt  = 1'b1;
        d.state   = mode[`MODE_CONT_BIT] ? ST_START : ST_IDLE; // see [R1] [R19]
      end
      ST_IDLE: begin
        d.state = ST_IDLE; // see [R19]
      end
      default: begin
        d.state = ST_POWER_DOWN;
      end
    endcase

    // reads: data registers come straight from held results, never from the sequence
    if (reg_rd_i) begin
      case (reg_addr_i) // see [R5] [R10]
        `REG_CFG:     d.rdata = q.cfg;
        `REG_CURRENT: d.rdata = q.cur_out;
        `REG_BUS:     d.rdata = q.bus_out;
        `REG_POWER:   d.rdata = q.pwr_out;
        `REG_MASK: begin
          d.rdata                  = q.mask_bits;
          d.rdata[`MASK_READY_BIT] = q.ready;
        end
        default:      d.rdata = 16'h0000;
      endcase
    end
    if (mask_rd) begin
      d.ready = 1'b0; // see [R14]
    end

    if (mask_wr) begin
      d.mask_bits = reg_wdata_i & `MASK_WR_BITS; // see [R10]
    end

    // a configuration write aborts the sequence and discards partial sums, except a sample added in that same cycle, which starts the new sum
    if (cfg_wr) begin
      d.cfg     = reg_wdata_i; // see [R10]
      d.count   = '0;
      d.timer   = '0;
      acc_clear = 1'b1;
      load_evt  = 1'b0;
      if (new_is_pd) begin
        d.state = ST_POWER_DOWN; // see [R9] [R13]
      end else begin
        d.ready = 1'b0; // see [R13]
        // every write restarts, including a repeat of the same single-shot mode
        // a write during warm-up restarts the wait rather than cutting it short
        d.state = ((q.state == ST_POWER_DOWN) || (q.state == ST_WAKE)) ? ST_WAKE : ST_START; // see [R7] [R8] [R9] [R11]
      end
    end

    // a completion in the same cycle as a mask read still sets the flag; an active configuration write keeps it clear
    if ((q.state == ST_LOAD) && !(cfg_wr && !new_is_pd)) begin
      d.ready = 1'b1; // see [R12]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q             <= '0;
      q.state       <= ST_WAKE;
      q.cfg         <= `CFG_RESET;
      q.mask_bits   <= `MASK_RESET;
    end else begin
      q <= d;
    end
  end

  sample_accumulator u_accumulator (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clear_i   (acc_clear),
    .add_i     (acc_add),
    .shift_i   (avg_shift),
    .cur_i     (q.cur_sample),
    .bus_i     (q.bus_sample),
    .pwr_i     (d.pwr_sample),
    .cur_avg_o (cur_avg),
    .bus_avg_o (bus_avg),
    .pwr_avg_o (pwr_avg)
  );

  assign reg_rdata_o             = q.rdata;
  assign adc_start_o             = q.adc_start;
  assign adc_sel_bus_o           = q.adc_sel_bus;
  assign adc_conv_time_o         = q.adc_sel_bus ? q.cfg[`CFG_BUS_CT_HI:`CFG_BUS_CT_LO]
                                                 : q.cfg[`CFG_ISH_CT_HI:`CFG_ISH_CT_LO];
  assign analog_pd_o             = (q.state == ST_POWER_DOWN);
  assign conversion_ready_flag_o = q.ready;

endmodule : conversion_sequencer

// file: dv/adc_model.sv
// converter stand-in: answers the latest start after a fixed delay
`timescale 1ns/1ps
module adc_model #(parameter int DELAY = 20) (
  // clock
  input  wire logic        ref_clk_i,
  // request side
  input  wire logic        start_i,
  input  wire logic        sel_bus_i,
  input  wire logic [15:0] cur_code_i,
  input  wire logic [15:0] bus_code_i,
  // answer side
  output logic             done_o,
  output logic      [15:0] data_o
);
  int   cnt = 0;
  logic sel_q = 1'b0;
  initial begin
    done_o = 1'b0;
    data_o = 16'h0000;
  end
  // a new start abandons the conversion in flight
  always @(posedge ref_clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (start_i) begin
      cnt <= DELAY;
      sel_q <= sel_bus_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        done_o <= 1'b1;
        data_o <= sel_q ? bus_code_i : cur_code_i;
      end
    end
  end
endmodule : adc_model

// file: dv/conversion_sequencer_asserts.sv
// port-level checks of the conversion sequencer
`timescale 1ns/1ps
`include "pm_regs.svh"
module conversion_sequencer_asserts (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  // register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  // converter and status
  input wire logic        adc_start_o,
  input wire logic        adc_sel_bus_o,
  input wire logic        analog_pd_o,
  input wire logic        adc_done_i,
  input wire logic        conversion_ready_flag_o
);
  logic [2:0]  mode_q;
  logic [11:0] wake_q;
  // cycles since reset or power-down, saturating
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) mode_q <= 3'h7;
    else if (reg_wr_i && reg_addr_i == `REG_CFG) mode_q <= reg_wdata_i[2:0];
    if (reset_i || analog_pd_o) wake_q <= 12'h000;
    else if (wake_q != 12'hfff) wake_q <= wake_q + 12'h001;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_start_pulse; adc_start_o |=> !adc_start_o; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
  property p_bus_after_shunt;
    adc_done_i && !adc_sel_bus_o && mode_q[1:0] == 2'h3 && !reg_wr_i && !$past(reg_wr_i)
      |=> adc_start_o && adc_sel_bus_o;
  endproperty
  a_bus_after_shunt: assert property (p_bus_after_shunt) else $error("no bus start after shunt");
  property p_mode_sel;
    adc_start_o && !$past(reg_wr_i) |-> mode_q[1:0] == 2'h3 || adc_sel_bus_o == mode_q[1];
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("wrong channel for mode");
  property p_wake; adc_start_o |-> wake_q >= `WAKE_CYCLES - 2; endproperty
  a_wake: assert property (p_wake) else $error("start before wake time");
  property p_pd_exit; $fell(analog_pd_o) |-> $past(reg_wr_i, 1) || $past(reg_wr_i, 2); endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("left power-down unasked");
  property p_ready_set; $rose(conversion_ready_flag_o) |-> $past(adc_done_i, 3); endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready without finished set");
  property p_cfg_clear;
    reg_wr_i && reg_addr_i == `REG_CFG && reg_wdata_i[1:0] != 2'h0 |=> !conversion_ready_flag_o;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("config write kept ready");
  property p_pd_keep;
    reg_wr_i && reg_addr_i == `REG_CFG && reg_wdata_i[1:0] == 2'h0 && !$past(adc_done_i, 2)
      |=> $stable(conversion_ready_flag_o);
  endproperty
  a_pd_keep: assert property (p_pd_keep) else $error("power-down write moved ready");
  property p_read_clear;
    reg_rd_i && reg_addr_i == `REG_MASK && !$past(adc_done_i, 2) |=> !conversion_ready_flag_o;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("mask read kept ready");
  c_wake: cover property ($fell(analog_pd_o));
  c_bus: cover property (adc_start_o && adc_sel_bus_o);
  c_ready: cover property ($rose(conversion_ready_flag_o));
endmodule : conversion_sequencer_asserts
bind conversion_sequencer conversion_sequencer_asserts asrt_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .adc_start_o(adc_start_o), .adc_sel_bus_o(adc_sel_bus_o), .analog_pd_o(analog_pd_o),
  .adc_done_i(adc_done_i), .conversion_ready_flag_o(conversion_ready_flag_o));

// file: dv/power_monitor_conversion_sequencer_bench.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`include "pm_regs.svh"
module power_monitor_conversion_sequencer_bench;
  logic        ref_clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000, cur_code = 16'h0010, bus_code = 16'h2570, rd_q;
  logic [15:0] reg_rdata_o, adc_data_i;
  logic [2:0]  adc_conv_time_o;
  logic        adc_start_o, adc_sel_bus_o, analog_pd_o, adc_done_i, conversion_ready_flag_o;
  int          n_errors = 0, n_compared = 0, n_starts = 0, n_cyc = 0;
  conversion_sequencer dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .adc_start_o(adc_start_o), .adc_sel_bus_o(adc_sel_bus_o), .adc_conv_time_o(adc_conv_time_o),
    .analog_pd_o(analog_pd_o), .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
    .conversion_ready_flag_o(conversion_ready_flag_o));
  adc_model adc_u (.ref_clk_i(ref_clk_i), .start_i(adc_start_o), .sel_bus_i(adc_sel_bus_o),
    .cur_code_i(cur_code), .bus_code_i(bus_code), .done_o(adc_done_i), .data_o(adc_data_i));
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    n_cyc++;
    if (adc_start_o === 1'b1) n_starts++;
    if (n_cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    rd_q = reg_rdata_o;
  endtask : rd
  task automatic shot(input logic [15:0] c);
    n_starts = 0;
    wr(`REG_CFG, c);
  endtask : shot
  // bounded wait for the ready flag, then the number of conversions taken
  task automatic fin(input int ns);
    for (int i = 0; i < 4000 && conversion_ready_flag_o !== 1'b1; i++) @(negedge ref_clk_i);
    chk(16'(conversion_ready_flag_o), 16'h0001);
    chk(16'(n_starts), 16'(ns));
  endtask : fin
  task automatic t_single();
    // bus conversion-time code 5 in bits 8:6, shunt code 0
    shot(16'h0143);
    fin(2);
    chk(16'(adc_conv_time_o), 16'h0005);
    rd(`REG_CURRENT); chk(rd_q, 16'h0010);
    rd(`REG_BUS); chk(rd_q, 16'h2570);
    rd(`REG_POWER); chk(rd_q, 16'd23);
    rd(`REG_MASK); chk(rd_q, 16'h0008);
    chk(16'(conversion_ready_flag_o), 16'h0000);
    repeat (200) @(negedge ref_clk_i);
    chk(16'(n_starts), 16'd2);
  endtask : t_single
  task automatic t_negative();
    cur_code = 16'hfff0;
    shot(16'h0003);
    fin(2);
    rd(`REG_CURRENT); chk(rd_q, 16'hfff0);
    rd(`REG_POWER); chk(rd_q, 16'd23);
  endtask : t_negative
  task automatic t_average();
    cur_code = 16'h0020;
    shot(16'h0203);
    for (int i = 0; i < 2000 && n_starts < 3; i++) @(negedge ref_clk_i);
    rd(`REG_CURRENT); chk(rd_q, 16'hfff0);
    chk(16'(conversion_ready_flag_o), 16'h0000);
    fin(8);
    rd(`REG_CURRENT); chk(rd_q, 16'h0020);
    rd(`REG_POWER); chk(rd_q, 16'd47);
  endtask : t_average
  task automatic t_modes();
    // shunt conversion-time code 3 in bits 5:3
    shot(16'h0019);
    fin(1);
    chk(16'(adc_conv_time_o), 16'h0003);
    bus_code = 16'h0100;
    shot(16'h0002);
    fin(1);
    rd(`REG_BUS); chk(rd_q, 16'h0100);
    rd(`REG_POWER); chk(rd_q, 16'd1);
  endtask : t_modes
  task automatic t_power_down();
    int i;
    wr(`REG_CFG, 16'h0000);
    repeat (2) @(negedge ref_clk_i);
    chk(16'(analog_pd_o), 16'h0001);
    chk(16'(conversion_ready_flag_o), 16'h0001);
    wr(`REG_MASK, 16'hffff);
    rd(`REG_MASK); chk(rd_q, 16'hfc0b);
    rd(`REG_CFG); chk(rd_q, 16'h0000);
    n_starts = 0;
    repeat (100) @(negedge ref_clk_i);
    chk(16'(n_starts), 16'd0);
    shot(16'h0007);
    for (i = 0; i < 2000 && n_starts == 0; i++) @(negedge ref_clk_i);
    chk(16'(i >= `WAKE_CYCLES), 16'h0001);
    fin(2);
    rd(`REG_MASK);
    fin(4);
  endtask : t_power_down
  initial begin
    repeat (4) @(negedge ref_clk_i);
    reset_i = 1'b0;
    rd(`REG_CFG); chk(rd_q, `CFG_RESET);
    rd(`REG_MASK); chk(rd_q, `MASK_RESET);
    rd(8'h05); chk(rd_q, 16'h0000);
    t_single();
    t_negative();
    t_average();
    t_modes();
    t_power_down();
    end_sim();
  end
endmodule : power_monitor_conversion_sequencer_bench
